// File: rtl/sar_adc_pkg.sv
// Functional notes
// - bus high impedance if select high or convert low
// - byte select low MSB-first, high swaps lanes
// - select low, convert falling edge starts conversion
// - select low, convert rising edge enables bus
// - inputs OR'd; select falling with convert low starts
// - convert high, select falling drives result out
// - busy low during conversion, rises with valid data
// - both low at busy rise restarts at once
// - approximation register cleared at conversion start
// - start requests ignored while converting
// - sixteen bits resolved MSB down to LSB
// - finished word copied into sixteen-bit output latch
// - unipolar straight binary, bipolar two's complement
package sar_adc_pkg;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int CLK_PERIOD_PS = 25000;
	// length of one bit-decision step
	localparam int STEP_TIME_NS = 400;
	localparam int STEP_CYCLES = (STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STEP_CNT_W = $clog2(STEP_CYCLES);
	localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYCLES - 1);
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [WORD_W-1:0] MSB_WEIGHT = 16'h8000;
	localparam logic [WORD_W-1:0] LSB_WEIGHT = 16'h0001;
	localparam int BUF_DEPTH = 2;
	// host-side limits, kept for the checker
	localparam int ACQ_TIME_NS = 2000;
	localparam int START_PULSE_NS = 40;
	localparam int START_RELEASE_NS = 3000;
	localparam int START_PULSE_CYCLES = (START_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACQ_CYCLES = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int START_RELEASE_CYCLES = (START_RELEASE_NS * 1000) / CLK_PERIOD_PS;
	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_CLEAR,
		CONV_STEP,
		CONV_HANDOFF
	} conv_state_e;
endpackage : sar_adc_pkg

// File: rtl/sar_word_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module sar_word_buffer (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [sar_adc_pkg::WORD_W-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [sar_adc_pkg::WORD_W-1:0] out_data
);
	import sar_adc_pkg::*;

	logic [WORD_W-1:0] mem_q [BUF_DEPTH];
	logic [WORD_W-1:0] mem_d [BUF_DEPTH];
	logic wr_idx_q, wr_idx_d;
	logic rd_idx_q, rd_idx_d;
	logic [1:0] count_q, count_d;
	logic push, pop;

	// honest full and empty from the occupancy count
	assign in_ready = (count_q != 2'(BUF_DEPTH));
	assign out_valid = (count_q != 2'h0);
	assign out_data = mem_q[rd_idx_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// next pointers, count and storage
	always_comb begin
		mem_d = mem_q;
		wr_idx_d = wr_idx_q;
		rd_idx_d = rd_idx_q;
		count_d = count_q;
		if (push) begin
			mem_d[wr_idx_q] = in_data;
			wr_idx_d = ~wr_idx_q;
		end
		if (pop) begin
			rd_idx_d = ~rd_idx_q;
		end
		case ({push, pop})
			2'b10: count_d = count_q + 2'h1;
			2'b01: count_d = count_q - 2'h1;
			default: count_d = count_q;
		endcase
	end

	// register the buffer state
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_idx_q <= 1'b0;
			rd_idx_q <= 1'b0;
			count_q <= 2'h0;
			for (int i = 0; i < BUF_DEPTH; i++) begin
				mem_q[i] <= WORD_ZERO;
			end
		end else begin
			wr_idx_q <= wr_idx_d;
			rd_idx_q <= rd_idx_d;
			count_q <= count_d;
			mem_q <= mem_d;
		end
	end
endmodule : sar_word_buffer
`default_nettype wire

// File: rtl/sar_adc_conversion_readout.sv
`timescale 1ns/10ps
`default_nettype none
module sar_adc_conversion_readout (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// host controls, select and read/convert active low
	input wire logic cs_n,
	input wire logic rd_conv_n,
	input wire logic byte_sel,
	// variant strap: high selects two's complement coding
	input wire logic bipolar,
	// analog front end
	input wire logic cmp_keep,
	output logic [sar_adc_pkg::WORD_W-1:0] dac_trial,
	output logic sample_hold,
	// three-state result bus, oe low while driving
	output logic [sar_adc_pkg::WORD_W-1:0] result_bus,
	output logic result_bus_oe_n,
	// status
	output logic busy_n
);
	import sar_adc_pkg::*;

	// input history for edge detection
	logic cs_n_q, rc_n_q;
	logic start_lvl, start_lvl_prev, start_evt, read_lvl;

	// timebase
	logic [STEP_CNT_W-1:0] tick_cnt_q, tick_cnt_d;
	logic step_en_q, step_en_d;

	// conversion state
	conv_state_e state_q, state_d;
	logic [WORD_W-1:0] sar_q, sar_d;
	logic [WORD_W-1:0] weight_q, weight_d;
	logic [WORD_W-1:0] dac_q, dac_d;
	logic hold_q, hold_d;
	logic busy_n_q, busy_n_d;

	// result latch and bus
	logic [WORD_W-1:0] latch_q, latch_d;
	logic [WORD_W-1:0] bus_q, bus_d;
	logic oe_n_q, oe_n_d;

	// buffer handshake
	logic buf_in_valid, buf_in_ready;
	logic [WORD_W-1:0] buf_in_data;
	logic buf_out_valid, buf_out_ready;
	logic [WORD_W-1:0] buf_out_data;
	logic latch_load;

	// output coding of a finished approximation word
	function automatic logic [WORD_W-1:0] code_word(input logic [WORD_W-1:0] raw,
		input logic bip);
		code_word = raw ^ (bip ? MSB_WEIGHT : WORD_ZERO);
	endfunction : code_word

	// byte lane arrangement on the bus
	function automatic logic [WORD_W-1:0] lane_order(input logic [WORD_W-1:0] w,
		input logic swap);
		lane_order = swap ? {w[BYTE_W-1:0], w[WORD_W-1:BYTE_W]} : w;
	endfunction : lane_order

	// the two active-low controls act as one combined start level
	assign start_lvl = ~cs_n & ~rd_conv_n;
	assign start_lvl_prev = ~cs_n_q & ~rc_n_q;
	// falling edge of either control while the other is low
	assign start_evt = start_lvl & ~start_lvl_prev;
	// bus may drive only with select low and read/convert high
	assign read_lvl = ~cs_n & rd_conv_n;

	// control history registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cs_n_q <= 1'b1;
			rc_n_q <= 1'b1;
		end else begin
			cs_n_q <= cs_n;
			rc_n_q <= rd_conv_n;
		end
	end

	// free-running step timebase, restarted when a conversion begins
	always_comb begin
		tick_cnt_d = tick_cnt_q;
		step_en_d = 1'b0;
		if (state_q == CONV_CLEAR) begin
			tick_cnt_d = '0;
		end else if (tick_cnt_q == STEP_LAST) begin
			tick_cnt_d = '0;
			step_en_d = 1'b1;
		end else begin
			tick_cnt_d = tick_cnt_q + 1'b1;
		end
	end

	// register the timebase
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tick_cnt_q <= '0;
			step_en_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			step_en_q <= step_en_d;
		end
	end

	// word handed to the buffer once the last bit is decided
	assign buf_in_valid = (state_q == CONV_HANDOFF);
	assign buf_in_data = sar_q;

	// conversion sequencer
	always_comb begin
		state_d = state_q;
		sar_d = sar_q;
		weight_d = weight_q;
		dac_d = dac_q;
		hold_d = hold_q;
		busy_n_d = busy_n_q;
		case (state_q)
			CONV_IDLE: begin
				// a start level still present as the word loads restarts at once
				if (start_evt || (latch_load && start_lvl)) begin
					state_d = CONV_CLEAR;
					hold_d = 1'b1;
					busy_n_d = 1'b0;
				end else if (latch_load) begin
					busy_n_d = 1'b1;
				end
			end
			CONV_CLEAR: begin
				sar_d = WORD_ZERO;
				weight_d = MSB_WEIGHT;
				dac_d = MSB_WEIGHT;
				state_d = CONV_STEP;
			end
			CONV_STEP: begin
				// start requests have no effect here
				if (step_en_q) begin
					if (cmp_keep) begin
						sar_d = dac_q;
					end
					weight_d = weight_q >> 1;
					dac_d = (cmp_keep ? dac_q : sar_q) | (weight_q >> 1);
					if (weight_q == LSB_WEIGHT) begin
						state_d = CONV_HANDOFF;
						hold_d = 1'b0;
					end
				end
			end
			CONV_HANDOFF: begin
				// waits here while the buffer is full
				if (buf_in_ready) begin
					state_d = CONV_IDLE;
				end
			end
			default: begin
				state_d = CONV_IDLE;
				busy_n_d = 1'b1;
			end
		endcase
	end

	// register the sequencer
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= CONV_IDLE;
			sar_q <= WORD_ZERO;
			weight_q <= WORD_ZERO;
			dac_q <= WORD_ZERO;
			hold_q <= 1'b0;
			busy_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			sar_q <= sar_d;
			weight_q <= weight_d;
			dac_q <= dac_d;
			hold_q <= hold_d;
			busy_n_q <= busy_n_d;
		end
	end

	// latch takes a word only while the bus is not being read
	assign buf_out_ready = ~read_lvl & ~busy_n_q & (state_q == CONV_IDLE);
	assign latch_load = buf_out_valid & buf_out_ready;

	sar_word_buffer u_word_buffer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	// output latch and bus drive
	always_comb begin
		latch_d = latch_q;
		if (latch_load) begin
			latch_d = code_word(buf_out_data, bipolar);
		end
		oe_n_d = ~read_lvl;
		bus_d = read_lvl ? lane_order(latch_d, byte_sel) : WORD_ZERO;
	end

	// register latch and bus
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			latch_q <= WORD_ZERO;
			bus_q <= WORD_ZERO;
			oe_n_q <= 1'b1;
		end else begin
			latch_q <= latch_d;
			bus_q <= bus_d;
			oe_n_q <= oe_n_d;
		end
	end

	// every output straight from its register
	assign dac_trial = dac_q;
	assign sample_hold = hold_q;
	assign result_bus = bus_q;
	assign result_bus_oe_n = oe_n_q;
	assign busy_n = busy_n_q;
endmodule : sar_adc_conversion_readout
`default_nettype wire

// File: sim/sar_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none
module sar_cmp_model (
	// analog side
	input wire logic [15:0] dac_trial,
	input wire logic [15:0] level,
	output logic cmp_keep
);
	// keep a trial bit while the trial stays at or below the input
	assign cmp_keep = (dac_trial <= level);
endmodule : sar_cmp_model
`default_nettype wire

// File: sim/sar_adc_props.sv
`timescale 1ns/10ps
`default_nettype none
module sar_adc_props (
	// watched ports
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic rd_conv_n,
	input wire logic byte_sel,
	input wire logic [15:0] dac_trial,
	input wire logic sample_hold,
	input wire logic [15:0] result_bus,
	input wire logic result_bus_oe_n,
	input wire logic busy_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic rd_lvl;
	// read level of the combined controls
	assign rd_lvl = !cs_n && rd_conv_n;
	property p_hiz; (cs_n || !rd_conv_n) |=> result_bus_oe_n; endproperty
	a_hiz: assert property (p_hiz) else $error("bus driven outside read");
	property p_idle; result_bus_oe_n |-> result_bus == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("idle bus not zero");
	property p_drive; rd_lvl |=> !result_bus_oe_n; endproperty
	a_drive: assert property (p_drive) else $error("read not driven");
	property p_swap;
		rd_lvl [*3] ##0 $changed(byte_sel)
		|=> result_bus == {$past(result_bus[7:0]), $past(result_bus[15:8])};
	endproperty
	a_swap: assert property (p_swap) else $error("byte lanes not swapped");
	property p_start;
		busy_n && (cs_n || rd_conv_n) ##1 (!cs_n && !rd_conv_n) |=> !busy_n && sample_hold;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_bmin; $fell(busy_n) |-> !busy_n [*8]; endproperty
	a_bmin: assert property (p_bmin) else $error("busy too short");
	property p_bend; $fell(busy_n) |-> ##[250:1000] busy_n; endproperty
	a_bend: assert property (p_bend) else $error("busy never ends");
	property p_msb; $fell(busy_n) |-> ##[1:3] dac_trial == 16'h8000; endproperty
	a_msb: assert property (p_msb) else $error("first trial not msb");
	property p_order;
		sample_hold && $past(sample_hold, 2) && !$past(busy_n, 4) && $changed(dac_trial)
		&& dac_trial != 0
		|-> (dac_trial & -dac_trial) < ($past(dac_trial) & -$past(dac_trial));
	endproperty
	a_order: assert property (p_order) else $error("trial order wrong");
	property p_restart;
		$fell(sample_hold) ##0 (!cs_n && !rd_conv_n) [*3] |=> sample_hold;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart at busy rise");
endmodule : sar_adc_props
bind sar_adc_conversion_readout sar_adc_props sar_adc_props_i (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .cs_n(cs_n), .rd_conv_n(rd_conv_n), .byte_sel(byte_sel),
	.dac_trial(dac_trial), .sample_hold(sample_hold), .result_bus(result_bus),
	.result_bus_oe_n(result_bus_oe_n), .busy_n(busy_n));
`default_nettype wire

// File: sim/tb_sar_adc_conversion_readout.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_conversion_readout;
	import sar_adc_pkg::*;
	logic ref_clk = 0;
	logic sys_rst = 1;
	logic cs_n = 1;
	logic rd_conv_n = 1;
	logic byte_sel = 0;
	logic bipolar = 0;
	logic [15:0] level = 0;
	logic cmp_keep;
	logic [15:0] dac_trial;
	logic [15:0] result_bus;
	logic sample_hold;
	logic result_bus_oe_n;
	logic busy_n;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	// free-running clock
	initial forever #12.5 ref_clk = ~ref_clk;
	sar_adc_conversion_readout sar_adc_conversion_readout_i (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .cs_n(cs_n), .rd_conv_n(rd_conv_n), .byte_sel(byte_sel),
		.bipolar(bipolar), .cmp_keep(cmp_keep), .dac_trial(dac_trial),
		.sample_hold(sample_hold), .result_bus(result_bus),
		.result_bus_oe_n(result_bus_oe_n), .busy_n(busy_n));
	sar_cmp_model sar_cmp_model_i (.dac_trial(dac_trial), .level(level), .cmp_keep(cmp_keep));
	task automatic finish_test();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: word %h not %h", $time, got, exp);
		end
	endtask : chk_w
	task automatic chk_b(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: flag %b not %b", $time, got, exp);
		end
	endtask : chk_b
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	// expected bus word from input level, coding and lane order
	function automatic logic [15:0] exp_w(input logic [15:0] t, input logic b, input logic s);
		logic [15:0] w;
		w = b ? t ^ 16'h8000 : t;
		return s ? {w[7:0], w[15:8]} : w;
	endfunction : exp_w
	// cycle limit for a hang
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// conversions in both start modes, then reads in both lane orders
	initial begin
		logic [15:0] w;
		logic [15:0] prev;
		logic b;
		logic m;
		void'($urandom(32'hab665e77));
		tick(12);
		sys_rst <= 1'b0;
		tick(2);
		for (int i = 0; i < 8; i++) begin
			w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom());
			b = 1'($urandom());
			m = i[0];
			level <= w;
			bipolar <= b;
			byte_sel <= 1'b0;
			if (m) rd_conv_n <= 1'b0; else cs_n <= 1'b0;
			tick(1);
			if (m) cs_n <= 1'b0; else rd_conv_n <= 1'b0;
			tick(2);
			#1 chk_b(busy_n, 1'b0);
			chk_b(result_bus_oe_n, 1'b1);
			tick(1);
			rd_conv_n <= 1'b1;
			cs_n <= m;
			tick(2);
			#1 if (!m && i > 0) chk_w(result_bus, prev);
			cs_n <= 1'b1;
			tick(30);
			cs_n <= 1'b0;
			rd_conv_n <= 1'b0;
			tick(2);
			cs_n <= 1'b1;
			rd_conv_n <= 1'b1;
			tick(3);
			#1 chk_b(dac_trial == 16'h8000, 1'b0);
			for (int k = 0; k < 600 && busy_n !== 1'b1; k++) tick(1);
			#1 chk_b(busy_n, 1'b1);
			tick(ACQ_CYCLES);
			cs_n <= 1'b0;
			tick(2);
			#1 chk_w(result_bus, exp_w(w, b, 1'b0));
			byte_sel <= 1'b1;
			tick(2);
			#1 chk_w(result_bus, exp_w(w, b, 1'b1));
			cs_n <= 1'b1;
			tick(2);
			#1 chk_b(result_bus_oe_n, 1'b1);
			prev = exp_w(w, b, 1'b0);
		end
		// both controls held low across the end of a conversion
		level <= 16'h1234;
		byte_sel <= 1'b0;
		cs_n <= 1'b0;
		rd_conv_n <= 1'b0;
		tick(3);
		for (int k = 0; k < 600 && sample_hold !== 1'b0; k++) tick(1);
		tick(4);
		#1 chk_b(sample_hold, 1'b1);
		chk_b(busy_n, 1'b0);
		cs_n <= 1'b1;
		rd_conv_n <= 1'b1;
		for (int k = 0; k < 600 && busy_n !== 1'b1; k++) tick(1);
		tick(2);
		cs_n <= 1'b0;
		tick(2);
		#1 chk_w(result_bus, exp_w(16'h1234, bipolar, 1'b0));
		finish_test();
	end
endmodule : tb_sar_adc_conversion_readout
`default_nettype wire
